// file: include/bta_pkg.sv
// ==========================================================
// Branch trace and space id break package
package bta_pkg;

    // ======================================================
    // Register byte offsets
    localparam logic [7:0] ADR_SRC_BASE = 8'h00;
    localparam logic [7:0] ADR_TGT_BASE = 8'h20;
    localparam logic [7:0] ADR_CTRL = 8'h40;
    localparam logic [7:0] ADR_SPACE_ID_A = 8'h44;
    localparam logic [7:0] ADR_SPACE_ID_B = 8'h48;
    localparam logic [7:0] ADR_INT_STAT = 8'h4c;
    localparam logic [7:0] ADR_INT_MASK = 8'h50;

    // ======================================================
    // Field positions and widths
    localparam int ADDR_W = 28;
    localparam int VALID_BIT = 31;
    localparam int SPACE_ID_W = 8;
    localparam int CTRL_TRACE_EN_BIT = 0;
    localparam int INT_W = 2;
    localparam int INT_RECORD_BIT = 0;
    localparam int INT_LOST_BIT = 1;

    // ======================================================
    // Values after reset
    localparam logic CTRL_TRACE_EN_RST = 1'b0;
    localparam logic [7:0] SPACE_ID_RST = 8'h00;
    localparam logic [1:0] INT_STAT_RST = 2'h0;
    localparam logic [1:0] INT_MASK_RST = 2'h0;

    // ======================================================
    // Carriers
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } bta_wb_req_t;

    typedef struct packed {
        logic taken;
        logic [ADDR_W-1:0] src;
        logic [ADDR_W-1:0] dst;
    } bta_branch_t;

endpackage : bta_pkg

// file: hdl/bta_top.sv
// Decided for this implementation: the address map and the Wishbone register port.
`timescale 1ns/10ps
module bta_top #(
    parameter int QDEPTH = 8
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire bta_pkg::bta_wb_req_t i_wb,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire bta_pkg::bta_branch_t i_branch,
    input wire logic [7:0] i_cur_asid,
    output logic o_asid_match_a,
    output logic o_asid_match_b,
    output logic o_irq
);

    // ======================================================
    // Storage
    logic [bta_pkg::ADDR_W-1:0] src_addr [QDEPTH];
    logic [bta_pkg::ADDR_W-1:0] tgt_addr [QDEPTH];
    logic [QDEPTH-1:0] src_valid;
    logic [QDEPTH-1:0] tgt_valid;
    logic trace_en;
    logic [7:0] space_id_a;
    logic [7:0] space_id_b;
    logic [bta_pkg::INT_W-1:0] int_stat;
    logic [bta_pkg::INT_W-1:0] int_mask;

    logic req;
    logic wr;
    logic rd;
    logic record;
    logic trace_clr;
    logic [QDEPTH-1:0] src_rd_hit;
    logic [QDEPTH-1:0] tgt_rd_hit;
    logic [QDEPTH-1:0] next_src_valid;
    logic [QDEPTH-1:0] next_tgt_valid;
    logic [bta_pkg::INT_W-1:0] next_int_stat;
    logic [bta_pkg::INT_W-1:0] int_event;
    logic [31:0] next_rdata;

    // ======================================================
    // Helpers
    function automatic logic [31:0] trace_word(input logic valid,
                                               input logic [bta_pkg::ADDR_W-1:0] addr);
        trace_word = {valid, 3'h0, addr};
    endfunction : trace_word

    function automatic logic [QDEPTH-1:0] queue_valid(input logic [QDEPTH-1:0] valid,
                                                      input logic [QDEPTH-1:0] rd_hit,
                                                      input logic push,
                                                      input logic clr);
        logic [QDEPTH-1:0] keep;
        keep = clr ? '0 : (valid & ~rd_hit);
        if (push) begin
            queue_valid = {keep[QDEPTH-2:0], 1'b1};
        end else begin
            queue_valid = keep;
        end
    endfunction : queue_valid

    function automatic logic in_region(input logic [7:0] adr, input logic [7:0] base);
        in_region = (adr[7:5] == base[7:5]) && (32'(adr[4:2]) < QDEPTH);
    endfunction : in_region

    // ======================================================
    // Bus decode
    assign req = i_wb.cyc & i_wb.stb & ~o_wb_ack;
    assign wr = req & i_wb.we;
    assign rd = req & ~i_wb.we;
    assign record = i_branch.taken & trace_en;
    assign trace_clr = wr && (i_wb.adr == bta_pkg::ADR_CTRL) && i_wb.sel[0]
                       && i_wb.dat[bta_pkg::CTRL_TRACE_EN_BIT];

    always_comb begin
        for (int i = 0; i < QDEPTH; i++) begin
            src_rd_hit[i] = rd && in_region(i_wb.adr, bta_pkg::ADR_SRC_BASE)
                            && (32'(i_wb.adr[4:2]) == i);
            tgt_rd_hit[i] = rd && in_region(i_wb.adr, bta_pkg::ADR_TGT_BASE)
                            && (32'(i_wb.adr[4:2]) == i);
        end
    end

    // ======================================================
    // Valid flags
    assign next_src_valid = queue_valid(src_valid, src_rd_hit, record, trace_clr);
    assign next_tgt_valid = queue_valid(tgt_valid, tgt_rd_hit, record, trace_clr);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            src_valid <= '0;
            tgt_valid <= '0;
        end else begin
            src_valid <= next_src_valid;
            tgt_valid <= next_tgt_valid;
        end
    end

    // ======================================================
    // Address queues, never reset
    always_ff @(posedge i_clk) begin
        if (record) begin
            src_addr[0] <= i_branch.src;
            tgt_addr[0] <= i_branch.dst;
            for (int i = 1; i < QDEPTH; i++) begin
                src_addr[i] <= src_addr[i-1];
                tgt_addr[i] <= tgt_addr[i-1];
            end
        end
    end

    // ======================================================
    // Control and space id registers
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            trace_en <= bta_pkg::CTRL_TRACE_EN_RST;
        end else if (wr && (i_wb.adr == bta_pkg::ADR_CTRL) && i_wb.sel[0]) begin
            trace_en <= i_wb.dat[bta_pkg::CTRL_TRACE_EN_BIT];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            space_id_a <= bta_pkg::SPACE_ID_RST;
            space_id_b <= bta_pkg::SPACE_ID_RST;
        end else if (wr && i_wb.sel[0]) begin
            if (i_wb.adr == bta_pkg::ADR_SPACE_ID_A) begin
                space_id_a <= i_wb.dat[7:0];
            end
            if (i_wb.adr == bta_pkg::ADR_SPACE_ID_B) begin
                space_id_b <= i_wb.dat[7:0];
            end
        end
    end

    // ======================================================
    // Space id match terms
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_asid_match_a <= 1'b0;
            o_asid_match_b <= 1'b0;
        end else begin
            o_asid_match_a <= (i_cur_asid == space_id_a);
            o_asid_match_b <= (i_cur_asid == space_id_b);
        end
    end

    // ======================================================
    // Interrupts
    always_comb begin
        int_event = '0;
        int_event[bta_pkg::INT_RECORD_BIT] = record;
        int_event[bta_pkg::INT_LOST_BIT] = record & src_valid[QDEPTH-1];
        next_int_stat = int_stat;
        if (wr && (i_wb.adr == bta_pkg::ADR_INT_STAT) && i_wb.sel[0]) begin
            next_int_stat = int_stat & ~i_wb.dat[bta_pkg::INT_W-1:0];
        end
        next_int_stat = next_int_stat | int_event;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            int_stat <= bta_pkg::INT_STAT_RST;
            o_irq <= 1'b0;
        end else begin
            int_stat <= next_int_stat;
            o_irq <= |(next_int_stat & int_mask);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            int_mask <= bta_pkg::INT_MASK_RST;
        end else if (wr && (i_wb.adr == bta_pkg::ADR_INT_MASK) && i_wb.sel[0]) begin
            int_mask <= i_wb.dat[bta_pkg::INT_W-1:0];
        end
    end

    // ======================================================
    // Read data and acknowledge
    always_comb begin
        next_rdata = 32'h0;
        if (in_region(i_wb.adr, bta_pkg::ADR_SRC_BASE)) begin
            next_rdata = trace_word(src_valid[i_wb.adr[4:2]], src_addr[i_wb.adr[4:2]]);
        end else if (in_region(i_wb.adr, bta_pkg::ADR_TGT_BASE)) begin
            next_rdata = trace_word(tgt_valid[i_wb.adr[4:2]], tgt_addr[i_wb.adr[4:2]]);
        end else begin
            case (i_wb.adr)
                bta_pkg::ADR_CTRL: next_rdata[bta_pkg::CTRL_TRACE_EN_BIT] = trace_en;
                bta_pkg::ADR_SPACE_ID_A: next_rdata[7:0] = space_id_a;
                bta_pkg::ADR_SPACE_ID_B: next_rdata[7:0] = space_id_b;
                bta_pkg::ADR_INT_STAT: next_rdata[bta_pkg::INT_W-1:0] = int_stat;
                bta_pkg::ADR_INT_MASK: next_rdata[bta_pkg::INT_W-1:0] = int_mask;
                default: next_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0;
        end else begin
            o_wb_ack <= req;
            o_wb_dat <= rd ? next_rdata : 32'h0;
        end
    end

    // ======================================================
    // Checks
    default clocking chk_cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    src_capture_a: assert property (record |=> src_addr[0] == $past(i_branch.src))
        else $error("source address not captured");
    src_valid_set_a: assert property (record |=> src_valid[0] && tgt_valid[0])
        else $error("valid flag not set on branch");
    src_read_clr_a: assert property ((src_rd_hit[0] && !record) |=> !src_valid[0])
        else $error("source flag survived read");
    enable_clr_a: assert property ((trace_clr && !record) |=> (src_valid | tgt_valid) == '0)
        else $error("flags survived trace enable");
    tgt_read_clr_a: assert property ((tgt_rd_hit[1] && !record) |=> !tgt_valid[1])
        else $error("target flag survived read");
    src_shift_a: assert property (record |=> !$past(src_valid[0])
                                  || src_addr[1] == $past(src_addr[0]))
        else $error("source queue did not shift");
    tgt_shift_a: assert property (record |=> tgt_addr[0] == $past(i_branch.dst)
                                  && (!$past(tgt_valid[0]) || tgt_addr[1] == $past(tgt_addr[0])))
        else $error("target queue did not shift");
    reserved_zero_a: assert property (o_wb_ack |-> o_wb_dat[30:28] == 3'h0)
        else $error("reserved bits not zero");
    queue_hold_a: assert property (!trace_en |=> $stable(src_addr[0]) && $stable(tgt_addr[0]))
        else $error("queue moved while tracing off");
    id_a_write_a: assert property (wr && i_wb.sel[0]
                                   && i_wb.adr == bta_pkg::ADR_SPACE_ID_A
                                   |=> space_id_a == $past(i_wb.dat[7:0]))
        else $error("space id A not written");
    id_b_write_a: assert property (wr && i_wb.sel[0]
                                   && i_wb.adr == bta_pkg::ADR_SPACE_ID_B
                                   |=> space_id_b == $past(i_wb.dat[7:0]))
        else $error("space id B not written");
    match_term_a: assert property ((i_cur_asid != space_id_b) |=> !o_asid_match_b)
        else $error("channel B match without equal id");
    ack_pulse_a: assert property (req |=> o_wb_ack ##1 !o_wb_ack)
        else $error("ack not a single cycle");

endmodule : bta_top

// file: dv/bta_cpu_model.sv
`timescale 1ns/10ps
// ==========================================================
// CPU core side: branch reports and current space id
module bta_cpu_model (
    input wire logic i_clk,
    output bta_pkg::bta_branch_t o_branch,
    output logic [7:0] o_cur_asid
);
    initial begin
        o_branch = '0;
        o_cur_asid = 8'h00;
    end
    // One report per call; consecutive calls give back-to-back branches
    task automatic report(input logic [27:0] s, input logic [27:0] d);
        @(posedge i_clk);
        o_branch <= '{taken: 1'b1, src: s, dst: d};
    endtask : report
    // Released address lines stop showing the last address
    task automatic idle();
        @(posedge i_clk);
        o_branch <= '{taken: 1'b0, src: ~o_branch.src, dst: ~o_branch.dst};
    endtask : idle
    task automatic set_asid(input logic [7:0] v);
        @(posedge i_clk);
        o_cur_asid <= v;
    endtask : set_asid
endmodule : bta_cpu_model

// file: dv/testbench.sv
`timescale 1ns/10ps
// ==========================================================
// Bench with queue model of the trace registers
module testbench;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    bta_pkg::bta_wb_req_t wb = '0;
    bta_pkg::bta_branch_t br;
    logic [31:0] o_wb_dat, rd;
    logic o_wb_ack, o_asid_match_a, o_asid_match_b, o_irq, en;
    logic [7:0] asid, ida, idb;
    logic [1:0] stat, msk;
    logic [31:0] src_q[$], dst_q[$];
    int num_errors = 0;
    int check_count = 0;
    always #5 i_clk = ~i_clk;
    bta_top DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_wb(wb), .o_wb_dat(o_wb_dat),
        .o_wb_ack(o_wb_ack), .i_branch(br), .i_cur_asid(asid),
        .o_asid_match_a(o_asid_match_a), .o_asid_match_b(o_asid_match_b), .o_irq(o_irq));
    bta_cpu_model cpu (.i_clk(i_clk), .o_branch(br), .o_cur_asid(asid));
    // ==========================================================
    // Checks, bus cycles and model
    task automatic check(input string w, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", w, e, g);
        end
    endtask : check
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        wb <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
        do begin
            @(posedge i_clk);
            n++;
        end while (o_wb_ack !== 1'b1 && n < 20);
        check("ack", 32'h1, {31'h0, o_wb_ack});
        rd = o_wb_dat;
        wb <= '0;
    endtask : bus
    task automatic clr();
        foreach (src_q[i]) begin
            src_q[i][31] = 1'b0;
            dst_q[i][31] = 1'b0;
        end
    endtask : clr
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
        if (a == bta_pkg::ADR_CTRL) en = d[0];
        if (a == bta_pkg::ADR_CTRL && d[0]) clr();
        if (a == bta_pkg::ADR_INT_STAT) stat = stat & ~d[1:0];
        if (a == bta_pkg::ADR_INT_MASK) msk = d[1:0];
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        bus(1'b0, a, 32'h0);
        check($sformatf("reg %h", a), e & m, rd & m);
        if (a < 8'h20) src_q[a[4:2]][31] = 1'b0;
        else if (a < 8'h40) dst_q[a[4:2]][31] = 1'b0;
    endtask : rc
    task automatic scan(input logic [31:0] m);
        for (int i = 0; i < 16; i++) rc(8'(4 * i), i < 8 ? src_q[i] : dst_q[i - 8], m);
    endtask : scan
    task automatic burst(input int n);
        logic [27:0] s, d;
        for (int k = 0; k < n; k++) begin
            s = 28'($urandom);
            d = 28'($urandom);
            cpu.report(s, d);
            if (en) begin
                stat = {stat[1] | src_q[7][31], 1'b1};
                src_q.push_front({4'h8, s});
                dst_q.push_front({4'h8, d});
                void'(src_q.pop_back());
                void'(dst_q.pop_back());
            end
        end
        cpu.idle();
    endtask : burst
    task automatic irq_chk();
        repeat (2) @(posedge i_clk);
        check("irq", {31'h0, |(stat & msk)}, {31'h0, o_irq});
    endtask : irq_chk
    task automatic asid_chk(input logic [7:0] v);
        cpu.set_asid(v);
        repeat (2) @(posedge i_clk);
        check("match", {30'h0, ida == v, idb == v}, {30'h0, o_asid_match_a, o_asid_match_b});
    endtask : asid_chk
    task automatic conclude();
        if (num_errors == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    task automatic do_reset();
        i_rst_n <= 1'b0;
        repeat (3) @(posedge i_clk);
        i_rst_n <= 1'b1;
        clr();
        {en, stat, msk, ida, idb} = '0;
    endtask : do_reset
    // ==========================================================
    // Tests
    initial begin
        repeat (20000) @(posedge i_clk);
        num_errors++;
        conclude();
    end
    initial begin
        void'($urandom(27366));
        for (int i = 0; i < 8; i++) src_q.push_back(32'h0);
        for (int i = 0; i < 8; i++) dst_q.push_back(32'h0);
        do_reset();
        scan(32'hf000_0000);
        burst(2);
        scan(32'hf000_0000);
        wr(bta_pkg::ADR_CTRL, 32'h1);
        burst(10);
        scan(32'hffff_ffff);
        scan(32'hffff_ffff);
        rc(bta_pkg::ADR_INT_STAT, {30'h0, stat}, 32'hffff_ffff);
        irq_chk();
        wr(bta_pkg::ADR_INT_MASK, 32'h1);
        irq_chk();
        wr(bta_pkg::ADR_INT_STAT, 32'h3);
        irq_chk();
        burst(3);
        irq_chk();
        wr(bta_pkg::ADR_CTRL, 32'h1);
        scan(32'hffff_ffff);
        ida = 8'($urandom);
        idb = ida ^ 8'h5a;
        wr(bta_pkg::ADR_SPACE_ID_A, {24'h0, ida});
        wr(bta_pkg::ADR_SPACE_ID_B, {24'h0, idb});
        rc(bta_pkg::ADR_SPACE_ID_A, {24'h0, ida}, 32'hffff_ffff);
        rc(bta_pkg::ADR_SPACE_ID_B, {24'h0, idb}, 32'hffff_ffff);
        asid_chk(ida);
        asid_chk(idb);
        wr(8'h60, 32'hffff_ffff);
        rc(8'h60, 32'h0, 32'hffff_ffff);
        burst(4);
        do_reset();
        scan(32'hffff_ffff);
        rc(bta_pkg::ADR_SPACE_ID_A, 32'h0, 32'hffff_ffff);
        conclude();
    end
endmodule : testbench
